// file: rsf_pkg.sv
// package: constants, register map and types of the remote signal failsafe
package rsf_pkg;

  // number of transferred binary signals
  localparam int NUM_SIG = 16;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFS_FALLBACK = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAPTURE = 8'h08;

  // field positions
  localparam int FB_FIELD_W = 2;
  localparam int ST_LINK_BIT = 0;
  localparam int ST_FRESH_BIT = 1;
  localparam int ST_TRIP_BIT = 2;
  localparam int ST_RX_LSB = 16;
  localparam int CAP_VAL_LSB = 0;
  localparam int CAP_SET_LSB = 16;

  // reset values
  localparam logic [31:0] FALLBACK_RST = 32'h0000_0000;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
  localparam logic [15:0] SIG_ZERO = 16'h0000;
  localparam logic [2:0] SYNC_RST = 3'h0;

  // per-signal fallback when the link is down
  typedef enum logic [1:0] {
    FB_FIXED0,
    FB_FIXED1,
    FB_CAP_INIT0,
    FB_CAP_INIT1
  } rsf_fallback_t;

  // one frame over the protection link
  typedef struct packed {
    logic trip;
    logic [15:0] sig;
  } rsf_frame_t;

endpackage

// file: rsf_hold_mem.sv
// retained store of the last validly received signal values
`timescale 1ns/1ps

module rsf_hold_mem (
  // clock and cold initialisation
  input wire logic clk,
  input wire logic init,
  // write side
  input wire logic wr_en,
  input wire logic [15:0] wr_data,
  // registered read side
  output logic [15:0] rd_data,
  output logic [15:0] rd_set
);

  logic [15:0] mem_val;
  logic [15:0] mem_set;

  // storage ignores the core reset so the held values survive it;
  // only an explicit cold init wipes them
  always_ff @(posedge clk) begin
    if (init) begin
      mem_val <= 16'h0000;
      mem_set <= 16'h0000;
    end else if (wr_en) begin
      mem_val <= wr_data;
      mem_set <= 16'hFFFF;
    end
  end

  // read data always come out of a register
  always_ff @(posedge clk) begin
    rd_data <= mem_val;
    rd_set <= mem_set;
  end

  chk_store_write: assert property (@(posedge clk)
    wr_en && !init |=> ##1 rd_data == $past(wr_data, 2) && &rd_set)
    else $error("held value not stored");

endmodule

// file: rsf_top.sv
// remote binary signal transfer with per-signal link-loss fallback
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/1ps

module rsf_top (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic NV_INIT,
  // wishbone classic slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // local send side
  input wire logic [15:0] SEND_SIGNALS,
  input wire logic RESTRAINED_DIFF_TRIP,
  input wire logic HIGHSET_DIFF_TRIP,
  output rsf_pkg::rsf_frame_t TX_FRAME,
  // link receiver side
  input wire logic LINK_UP,
  input wire logic RX_VALID,
  input wire rsf_pkg::rsf_frame_t RX_FRAME,
  // local digital inputs and trip command
  output logic [15:0] RX_SIGNALS,
  output logic TRANSFER_TRIP_COMMAND,
  output logic LINK_OK
);

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  logic [2:0] link_sync;
  logic link_ok;
  logic fresh;
  logic live_valid;
  logic [15:0] live;
  logic live_trip;
  logic [31:0] fb_cfg;
  logic [15:0] cap_rd;
  logic [15:0] cap_set;
  logic [15:0] held;
  logic [15:0] next_rx;
  logic frame_ok;
  logic wb_req;
  logic [31:0] next_rdata;

  // link status pin crosses three stages; a change counts when the last
  // two agree, so one glitchy sample cannot flap the fallback
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      link_sync <= rsf_pkg::SYNC_RST;
    end else begin
      link_sync <= {link_sync[1:0], LINK_UP};
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      link_ok <= 1'b0;
    end else if (link_sync[1] == link_sync[2]) begin
      link_ok <= link_sync[2];
    end
  end

  // a frame only counts while the link is declared up
  assign frame_ok = RX_VALID & link_ok;

  // live copy of the last valid frame
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      live <= rsf_pkg::SIG_ZERO;
      live_trip <= 1'b0;
    end else if (frame_ok) begin
      live <= RX_FRAME.sig;
      live_trip <= RX_FRAME.trip;
    end
  end

  // live_valid: a frame arrived since reset; fresh: since the link came up
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      live_valid <= 1'b0;
      fresh <= 1'b0;
    end else begin
      if (frame_ok) begin
        live_valid <= 1'b1;
      end
      if (!link_ok) begin
        fresh <= 1'b0;
      end else if (frame_ok) begin
        fresh <= 1'b1;
      end
    end
  end

  // retained capture store, written on every valid frame
  rsf_hold_mem u_hold (
    .clk(CORE_CLK),
    .init(NV_INIT),
    .wr_en(frame_ok),
    .wr_data(RX_FRAME.sig),
    .rd_data(cap_rd),
    .rd_set(cap_set)
  );

  // the live copy equals the store once a frame came in this run; the
  // store is used only after reset, which avoids its read latency race
  assign held = live_valid ? live : cap_rd;

  // per-signal output choice: live data while fresh, fallback otherwise
  always_comb begin
    next_rx = rsf_pkg::SIG_ZERO;
    for (int i = 0; i < rsf_pkg::NUM_SIG; i++) begin
      if (link_ok && fresh) begin
        next_rx[i] = live[i];
      end else begin
        unique case (rsf_pkg::rsf_fallback_t'(fb_cfg[2*i +: 2]))
          rsf_pkg::FB_FIXED0: next_rx[i] = 1'b0;
          rsf_pkg::FB_FIXED1: next_rx[i] = 1'b1;
          rsf_pkg::FB_CAP_INIT0: begin
            next_rx[i] = (live_valid || cap_set[i]) ? held[i] : 1'b0;
          end
          rsf_pkg::FB_CAP_INIT1: begin
            next_rx[i] = (live_valid || cap_set[i]) ? held[i] : 1'b1;
          end
        endcase
      end
    end
  end

  // received signals feed the local digital inputs
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      RX_SIGNALS <= rsf_pkg::SIG_ZERO;
    end else begin
      RX_SIGNALS <= next_rx;
    end
  end

  // trip command passes only on a live link, never from a stale capture
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TRANSFER_TRIP_COMMAND <= 1'b0;
    end else begin
      TRANSFER_TRIP_COMMAND <= link_ok & fresh & live_trip;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      LINK_OK <= 1'b0;
    end else begin
      LINK_OK <= link_ok;
    end
  end

  // send frame: both differential trips share one trip bit
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      TX_FRAME <= '0;
    end else begin
      TX_FRAME.sig <= SEND_SIGNALS;
      TX_FRAME.trip <= RESTRAINED_DIFF_TRIP | HIGHSET_DIFF_TRIP;
    end
  end

  // wishbone: one ack per request, dropped in the following cycle
  assign wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      WB_ACK_O <= 1'b0;
    end else begin
      WB_ACK_O <= wb_req;
    end
  end

  // fallback register, byte lanes honoured; reset is fixed zero everywhere
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      fb_cfg <= rsf_pkg::FALLBACK_RST;
    end else if (wb_req && WB_WE_I && WB_ADR_I == rsf_pkg::OFS_FALLBACK) begin
      for (int k = 0; k < 4; k++) begin
        if (WB_SEL_I[k]) begin
          fb_cfg[8*k +: 8] <= WB_DAT_I[8*k +: 8];
        end
      end
    end
  end

  // read mux; unmapped offsets answer with zero and ignore writes
  always_comb begin
    next_rdata = rsf_pkg::DATA_ZERO;
    unique case (WB_ADR_I)
      rsf_pkg::OFS_FALLBACK: next_rdata = fb_cfg;
      rsf_pkg::OFS_STATUS: begin
        next_rdata[rsf_pkg::ST_LINK_BIT] = link_ok;
        next_rdata[rsf_pkg::ST_FRESH_BIT] = fresh;
        next_rdata[rsf_pkg::ST_TRIP_BIT] = TRANSFER_TRIP_COMMAND;
        next_rdata[rsf_pkg::ST_RX_LSB +: 16] = RX_SIGNALS;
      end
      rsf_pkg::OFS_CAPTURE: begin
        next_rdata[rsf_pkg::CAP_VAL_LSB +: 16] = held;
        next_rdata[rsf_pkg::CAP_SET_LSB +: 16] = cap_set;
      end
      default: next_rdata = rsf_pkg::DATA_ZERO;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      WB_DAT_O <= rsf_pkg::DATA_ZERO;
    end else if (wb_req && !WB_WE_I) begin
      WB_DAT_O <= next_rdata;
    end
  end

  // checks on the behaviour above

  chk_trip_blocked_down: assert property (
    !link_ok |=> !TRANSFER_TRIP_COMMAND)
    else $error("trip passed while link down");

  chk_fixed_zero: assert property (
    !link_ok && fb_cfg[1:0] == 2'h0 |=> RX_SIGNALS[0] == 1'b0)
    else $error("fixed zero fallback not applied");

  chk_fixed_one: assert property (
    !link_ok && fb_cfg[3:2] == 2'h1 |=> RX_SIGNALS[1] == 1'b1)
    else $error("fixed one fallback not applied");

  chk_capture_init_zero: assert property (
    !link_ok && fb_cfg[5:4] == 2'h2 && !live_valid && !cap_set[2]
    |=> RX_SIGNALS[2] == 1'b0)
    else $error("capture init zero wrong");

  chk_capture_init_one: assert property (
    !link_ok && fb_cfg[7:6] == 2'h3 && !live_valid && !cap_set[3]
    |=> RX_SIGNALS[3] == 1'b1)
    else $error("capture init one wrong");

  chk_capture_hold: assert property (
    !link_ok && fb_cfg[5:4] == 2'h2 && live_valid
    |=> RX_SIGNALS[2] == $past(live[2]))
    else $error("captured value not held");

  chk_live_pass: assert property (
    link_ok && fresh |=> RX_SIGNALS == $past(live))
    else $error("live signals not passed");

  chk_frame_capture: assert property (
    frame_ok |=> live == $past(RX_FRAME.sig) && live_valid ##1 fresh || !link_ok)
    else $error("valid frame not captured");

  chk_no_update_down: assert property (
    !link_ok |=> $stable(live) && $stable(live_trip))
    else $error("frame taken while link down");

  chk_send_path: assert property (
    1'b1 |=> TX_FRAME.sig == $past(SEND_SIGNALS)
      && TX_FRAME.trip == $past(RESTRAINED_DIFF_TRIP | HIGHSET_DIFF_TRIP))
    else $error("send frame mismatch");

  chk_ack_single: assert property (
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack held more than one cycle");

  cov_link_drop: cover property ($fell(link_ok) && live_valid);
  cov_trip_out: cover property ($rose(TRANSFER_TRIP_COMMAND));
  cov_capture_down: cover property (!link_ok && fb_cfg[1] && live_valid);
  cov_reg_write: cover property (wb_req && WB_WE_I);

endmodule

// file: rsf_peer_model.sv
// peer model: far end of the link, hands frames to the receiver
`timescale 1ns/1ps

module rsf_peer_model (
  // clock and bench commands
  input wire logic clk,
  input wire logic link_en,
  input wire logic send,
  input wire rsf_pkg::rsf_frame_t data,
  // receiver side
  output logic link_up,
  output logic rx_valid,
  output rsf_pkg::rsf_frame_t rx_frame
);
  initial begin
    link_up = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // valid marks one whole frame for one cycle only
  always @(posedge clk) begin
    link_up <= link_en;
    rx_valid <= send;
  end
  // outside a valid cycle the lines toggle so stale data never matches
  always @(posedge clk) begin
    if (send) begin
      rx_frame <= data;
    end else begin
      rx_frame <= ~rx_frame;
    end
  end
endmodule

// file: testbench.sv
// self-checking bench of the remote signal failsafe
`timescale 1ns/1ps

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic nv = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0000_0000;
  logic [3:0] sel = 4'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic ack;
  logic [15:0] ss = 16'h0000;
  logic tr = 1'b0;
  logic th = 1'b0;
  logic len = 1'b0;
  logic snd = 1'b0;
  rsf_pkg::rsf_frame_t pd = '0;
  rsf_pkg::rsf_frame_t txf;
  rsf_pkg::rsf_frame_t rxf;
  logic lup;
  logic rxv;
  logic [15:0] rxs;
  logic tc;
  logic lok;
  logic [15:0] held;
  int n_fail = 0;
  int comparisons = 0;

  // 20 MHz core clock
  always #25 clk = ~clk;

  rsf_top rsf_top_inst (.CORE_CLK(clk), .RST(rst), .NV_INIT(nv),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wd), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .SEND_SIGNALS(ss), .RESTRAINED_DIFF_TRIP(tr), .HIGHSET_DIFF_TRIP(th),
    .TX_FRAME(txf), .LINK_UP(lup), .RX_VALID(rxv), .RX_FRAME(rxf),
    .RX_SIGNALS(rxs), .TRANSFER_TRIP_COMMAND(tc), .LINK_OK(lok));
  rsf_peer_model rsf_peer_model_inst (.clk(clk), .link_en(len),
    .send(snd), .data(pd), .link_up(lup), .rx_valid(rxv),
    .rx_frame(rxf));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle; ack and read data are taken at the rising edge that
  // samples ack high, and only then is the request released
  task automatic wbs(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= s;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  // full word access on all four byte lanes
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    wbs(w, a, d, 4'hF);
  endtask

  task automatic link(input logic v);
    int n;
    n = 0;
    @(posedge clk);
    len <= v;
    while (lok !== v && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) n_fail++;
    repeat (3) @(posedge clk);
  endtask

  task automatic frame(input logic t, input logic [15:0] s);
    @(posedge clk);
    snd <= 1'b1;
    pd <= {t, s};
    @(posedge clk);
    snd <= 1'b0;
    repeat (4) @(posedge clk);
  endtask

  task automatic s_reset();
    wb(1'b0, rsf_pkg::OFS_FALLBACK, 32'h0);
    chk(rd, rsf_pkg::FALLBACK_RST);
    chk(rxs, 16'h0000);
    wb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0000_0000);
  endtask

  // modes 0,1,2,3 repeat over the signals; nothing captured yet
  task automatic s_init();
    wb(1'b1, rsf_pkg::OFS_FALLBACK, 32'hE4E4_E4E4);
    wb(1'b0, rsf_pkg::OFS_FALLBACK, 32'h0);
    chk(rd, 32'hE4E4_E4E4);
    chk(rxs, 16'hAAAA);
    // one byte lane only: signals four to seven fall back to fixed zero
    wbs(1'b1, rsf_pkg::OFS_FALLBACK, 32'h0000_0000, 4'h2);
    wb(1'b0, rsf_pkg::OFS_FALLBACK, 32'h0);
    chk(rd, 32'hE4E4_00E4);
    chk(rxs, 16'hAA0A);
    // restore that lane with zeros on the others, which must be ignored
    wbs(1'b1, rsf_pkg::OFS_FALLBACK, 32'h0000_E400, 4'h2);
  endtask

  task automatic s_send();
    ss <= 16'h5A3C;
    tr <= 1'b1;
    repeat (3) @(posedge clk);
    chk(txf, {1'b1, 16'h5A3C});
    tr <= 1'b0;
    th <= 1'b1;
    repeat (3) @(posedge clk);
    chk(txf, {1'b1, 16'h5A3C});
    th <= 1'b0;
    repeat (3) @(posedge clk);
    chk(txf, {1'b0, 16'h5A3C});
  endtask

  task automatic s_live();
    link(1'b1);
    chk(rxs, 16'hAAAA);
    frame(1'b1, 16'h9C36);
    chk(rxs, 16'h9C36);
    chk(tc, 1'b1);
    held = 16'h6D1B;
    frame(1'b0, held);
    chk(rxs, held);
    chk(tc, 1'b0);
  endtask

  task automatic s_loss();
    tr <= 1'b1;
    frame(1'b1, 16'h1111);
    tr <= 1'b0;
    frame(1'b1, held);
    chk(tc, 1'b1);
    link(1'b0);
    chk(rxs, (held & 16'hCCCC) | 16'h2222);
    chk(tc, 1'b0);
    frame(1'b1, 16'hFFFF);
    chk(rxs, (held & 16'hCCCC) | 16'h2222);
    chk(tc, 1'b0);
    wb(1'b1, rsf_pkg::OFS_FALLBACK, 32'h0);
    repeat (3) @(posedge clk);
    chk(rxs, 16'h0000);
  endtask

  // a reset without cold init must keep the captured values
  task automatic s_keep();
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk(rxs, 16'h0000);
    wb(1'b1, rsf_pkg::OFS_FALLBACK, 32'hE4E4_E4E4);
    repeat (3) @(posedge clk);
    chk(rxs, (held & 16'hCCCC) | 16'h2222);
    wb(1'b0, rsf_pkg::OFS_STATUS, 32'h0);
    chk(rd[31:16], (held & 16'hCCCC) | 16'h2222);
    wb(1'b0, rsf_pkg::OFS_CAPTURE, 32'h0);
    chk(rd, {16'hFFFF, held});
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // main sequence after eight reset cycles with cold init of the store
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    nv <= 1'b0;
    s_reset();
    s_init();
    s_send();
    s_live();
    s_loss();
    s_keep();
    conclude();
  end

  // watchdog well beyond the roughly one hundred cycles the tests need
  initial begin
    #2000000;
    n_fail++;
    conclude();
  end
endmodule
